//--- rtl/lts_consts.vh
// Purpose: Constants for the serial transmit block
// Assumes: 32-bit AHB-Lite register words
// Notes:   Offsets are byte addresses
`ifndef LTS_CONSTS_VH
`define LTS_CONSTS_VH

`define LTS_OFF_CTRL      12'h000
`define LTS_OFF_DATA      12'h004
`define LTS_OFF_STATUS    12'h008
`define LTS_OFF_CLKDIV    12'h00c

`define LTS_CTRL_EN       0
`define LTS_CTRL_MODE_LO  1
`define LTS_CTRL_MODE_HI  2
`define LTS_CTRL_EMUL     3
`define LTS_CTRL_OE       4
`define LTS_CTRL_FWD      5
`define LTS_CTRL_FAC_LO   8
`define LTS_CTRL_FAC_HI   11

`define LTS_MODE_SER      2'h0
`define LTS_MODE_SDR      2'h1
`define LTS_MODE_DDR      2'h2

`define LTS_CTRL_RESET    32'h0000_0a00
`define LTS_FAC_MIN       4'h3
`define LTS_FAC_MAX       4'ha
`define LTS_WORD_MAX      10

`define LTS_MAX_RATE_MBPS 1434
`define LTS_CLK_MHZ       50
`define LTS_BIT_CYCLES    1

`endif

//--- rtl/lts_fifo.v
// Purpose: Word FIFO between the register bus and the serializer
// Assumes: One clock, combinational read of the entry at the read pointer
// Notes:   Depth must be a power of two
`timescale 1ns/10ps
module lts_fifo
#(
    parameter WIDTH = 10,
    parameter DEPTH = 16,
    parameter AW    = 4
)
(
    input  wire             hclk,
    input  wire             hresetn,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [AW:0]      level
);
    localparam [AW:0] FULL_LEVEL = DEPTH;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wptr;
    reg [AW:0]      rptr;
    wire            push;
    wire            pop;

    assign level     = wptr - rptr;
    assign in_ready  = (level != FULL_LEVEL);
    assign out_valid = (wptr != rptr);
    assign out_data  = mem[rptr[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge hclk)
    begin
        if (push)
            mem[wptr[AW-1:0]] <= in_data;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wptr <= {(AW+1){1'b0}};
            rptr <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wptr <= wptr + 1'b1;
            if (pop)
                rptr <= rptr + 1'b1;
        end
    end
endmodule

//--- rtl/lts_serializer.v
// Purpose: Parallel to serial transmitter with AHB-Lite control and word FIFO
// Assumes: hclk stands for the serial bit rate clock; one bit per hclk
// Notes:   Load strobe made internally from the serialization factor
//
// Behaviour
// - Capture up to ten bits, shift out
// - Most significant bit leaves first
// - Load by strobe, shift at bit rate
// - Static factor three to ten
// - One load per factor bits shifted
// - Bit clock and strobe from one source
// - Bypass width one SDR, two DDR
// - Emulated standard uses general logic path
// - Emulated output supports tri-state enable
// - Datapath runs one bit per clock
// - DDR bypass registered, SDR passes through
// - Forwarded clock divides by 4,6,8,10; odd factors forward the data bit
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/10ps
`include "lts_consts.vh"
module lts_serializer
#(
    parameter WORD_W = 10,
    parameter DEPTH  = 16,
    parameter AW     = 4
)
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg         tx_out,
    output reg         tx_out_emul_p,
    output reg         tx_out_emul_n,
    output reg         tx_out_emul_oe,
    output reg         tx_clk_out,
    output reg         load_strobe
);
    reg  [31:0]       ctrl;
    reg               ph_valid;
    reg               ph_write;
    reg  [11:0]       ph_addr;
    reg  [WORD_W-1:0] load_reg;
    reg  [WORD_W-1:0] shift_reg;
    reg  [3:0]        bit_cnt;
    reg               running;
    reg  [3:0]        div_cnt;
    reg               ddr_phase;
    reg  [1:0]        ddr_reg;
    reg               next_bit;
    reg               underrun;
    reg  [15:0]       word_count;
    reg  [31:0]       next_rdata;
    wire              fifo_in_ready;
    wire [WORD_W-1:0] fifo_data;
    wire              fifo_valid;
    wire [AW:0]       fifo_level;
    wire              wr_data;
    wire              enable;
    wire [1:0]        mode;
    wire [3:0]        factor;
    wire              take;
    wire [3:0]        eff_len;
    wire [3:0]        half_div;

    assign enable = ctrl[`LTS_CTRL_EN];
    assign mode   = ctrl[`LTS_CTRL_MODE_HI:`LTS_CTRL_MODE_LO];
    assign factor = ctrl[`LTS_CTRL_FAC_HI:`LTS_CTRL_FAC_LO];
    // Word length per load, bypass modes shrink it
    // bypass widths
    assign eff_len = (mode == `LTS_MODE_SDR) ? 4'h1 :
                     (mode == `LTS_MODE_DDR) ? 4'h2 : factor;
    // Load on the edge that puts the last bit of the current word onto the line
    // strobe from factor
    assign take    = enable && fifo_valid && (!running || bit_cnt == 4'h1);
    assign wr_data = ph_valid && ph_write && (ph_addr == `LTS_OFF_DATA);
    assign half_div = factor >> 1;

    // Writes to DATA stall while the FIFO is full
    lts_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH), .AW(AW)) u_fifo
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_data   (hwdata[WORD_W-1:0]),
        .in_valid  (wr_data),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (take),
        .level     (fifo_level)
    );

    // Bus address phase capture and data phase handling
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_valid  <= 1'b0;
            ph_write  <= 1'b0;
            ph_addr   <= 12'h000;
            ctrl      <= `LTS_CTRL_RESET;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end
        else
        begin
            if (ph_valid && !(wr_data && !fifo_in_ready))
            begin
                ph_valid  <= 1'b0;
                hreadyout <= 1'b1;
                if (ph_write && ph_addr == `LTS_OFF_CTRL)
                begin
                    ctrl <= hwdata & 32'h0000_0f3f;
                    if (hwdata[11:8] < `LTS_FAC_MIN)
                        ctrl[`LTS_CTRL_FAC_HI:`LTS_CTRL_FAC_LO] <= `LTS_FAC_MIN;
                    else if (hwdata[11:8] > `LTS_FAC_MAX)
                        ctrl[`LTS_CTRL_FAC_HI:`LTS_CTRL_FAC_LO] <= `LTS_FAC_MAX;
                end
            end
            if (hsel && hready && htrans[1] && !(ph_valid && !hreadyout))
            begin
                ph_valid  <= 1'b1;
                ph_write  <= hwrite;
                ph_addr   <= {haddr[11:2], 2'b00};
                hreadyout <= !(hwrite && haddr[11:2] == `LTS_OFF_DATA >> 2
                               && !fifo_in_ready);
                hrdata    <= next_rdata;
            end
            else if (ph_valid && wr_data && !fifo_in_ready)
                hreadyout <= 1'b0;
        end
    end

    always @*
    begin
        next_rdata = 32'h0000_0000;
        case ({haddr[11:2], 2'b00})
            `LTS_OFF_CTRL:   next_rdata = ctrl;
            `LTS_OFF_STATUS: next_rdata = {word_count, 9'h000, underrun,
                                           running, fifo_level};
            `LTS_OFF_CLKDIV: next_rdata = {28'h0000000, div_cnt};
            default:         next_rdata = 32'h0000_0000;
        endcase
    end

    // Serializer: load register and shift register both loaded from the FIFO
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            load_reg    <= {WORD_W{1'b0}};
            shift_reg   <= {WORD_W{1'b0}};
            bit_cnt     <= 4'h0;
            running     <= 1'b0;
            load_strobe <= 1'b0;
            underrun    <= 1'b0;
            word_count  <= 16'h0000;
        end
        else
        begin
            load_strobe <= take;
            if (take)
            begin
                load_reg   <= fifo_data;
                word_count <= word_count + 16'h0001;
            end
            if (take)
            begin
                shift_reg <= fifo_data << (WORD_W - eff_len);
                bit_cnt   <= eff_len;
                running   <= 1'b1;
                // Word ended with the next one ready, so no underrun
                if (running && bit_cnt == 4'h1)
                    underrun <= 1'b0;
            end
            else if (running)
            begin
                shift_reg <= shift_reg << 1;
                bit_cnt   <= bit_cnt - 4'h1;
                if (bit_cnt == 4'h1)
                begin
                    running  <= 1'b0;
                    underrun <= enable;
                end
            end
        end
    end

    // Line driver: serial, SDR pass-through or DDR register
    always @*
    begin
        next_bit = 1'b0;
        case (mode)
            `LTS_MODE_SER: next_bit = running & shift_reg[WORD_W-1];
            `LTS_MODE_SDR: next_bit = running & shift_reg[WORD_W-1];
            `LTS_MODE_DDR: next_bit = ddr_phase ? ddr_reg[0] : ddr_reg[1];
            default:       next_bit = 1'b0;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ddr_phase      <= 1'b0;
            ddr_reg        <= 2'h0;
            tx_out         <= 1'b0;
            tx_out_emul_p  <= 1'b0;
            tx_out_emul_n  <= 1'b1;
            tx_out_emul_oe <= 1'b0;
            div_cnt        <= 4'h0;
            tx_clk_out     <= 1'b0;
        end
        else
        begin
            // DDR pair held in output register
            if (take && mode == `LTS_MODE_DDR)
            begin
                ddr_reg   <= fifo_data[1:0];
                ddr_phase <= 1'b0;
            end
            else
                ddr_phase <= ~ddr_phase;
            if (ctrl[`LTS_CTRL_EMUL])
            begin
                tx_out        <= 1'b0;
                tx_out_emul_p <= next_bit;
                tx_out_emul_n <= ~next_bit;
            end
            else
                tx_out <= next_bit;
            tx_out_emul_oe <= ctrl[`LTS_CTRL_EMUL] & ctrl[`LTS_CTRL_OE];
            if (!ctrl[`LTS_CTRL_FWD] || factor < 4'h4 || factor[0])
                tx_clk_out <= next_bit;
            else if (div_cnt + 4'h1 >= half_div)
            begin
                div_cnt    <= 4'h0;
                tx_clk_out <= ~tx_clk_out;
            end
            else
                div_cnt <= div_cnt + 4'h1;
        end
    end
endmodule

//--- sim/lts_props_properties.sv
// Purpose: Port checks for the serial transmit block
// Assumes: One clock; bus slave answers with no wait except a full word queue
// Notes:   Bound onto every serializer instance
`timescale 1ns/10ps
`include "lts_consts.vh"
module lts_props
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        tx_out_emul_p,
    input wire logic        tx_out_emul_n,
    input wire logic        load_strobe
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire tk = hsel && hready && htrans[1];
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_pulse;
        load_strobe |=> !load_strobe;
    endproperty
    a_pulse: assert property (p_pulse) else $error("load strobe too long");
    property p_gap;
        load_strobe ##1 !load_strobe |=> !load_strobe;
    endproperty
    a_gap: assert property (p_gap) else $error("loads closer than three bits");
    property p_pair;
        tx_out_emul_p != tx_out_emul_n;
    endproperty
    a_pair: assert property (p_pair) else $error("emulated pair not complementary");
    property p_rd;
        tk && !hwrite |=> hreadyout;
    endproperty
    a_rd: assert property (p_rd) else $error("read stalled");
    property p_wr;
        tk && hwrite && haddr != `LTS_OFF_DATA |=> hreadyout;
    endproperty
    a_wr: assert property (p_wr) else $error("register write stalled");
    property p_unm;
        tk && !hwrite && haddr[11:4] != 8'h00 |=> hrdata == 32'h0;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_hold;
        !tk |=> $stable(hrdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind lts_serializer lts_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tx_out_emul_p(tx_out_emul_p),
    .tx_out_emul_n(tx_out_emul_n), .load_strobe(load_strobe));

//--- sim/lts_rx_model.sv
// Purpose: Receiver at the far end of the serial line
// Assumes: Load strobe comes one bit ahead of the first bit of a word
// Notes:   Only the low fac bits of rx_word are meaningful
`timescale 1ns/10ps
module lts_rx_model
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       tx_out,
    input  wire logic       load_strobe,
    input  wire logic [3:0] fac,
    output logic      [9:0] rx_word,
    output logic            rx_valid
);
    logic [3:0] cnt;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt <= 4'h0;
            rx_valid <= 1'b0;
            rx_word <= 10'h000;
        end
        else
        begin
            rx_valid <= (cnt == 4'h1);
            rx_word <= {rx_word[8:0], tx_out};
            if (load_strobe)
                cnt <= fac;
            else if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
        end
    end
endmodule

//--- sim/tb_top.sv
// Purpose: Bus driven tests of the serial transmit block
// Assumes: Zero wait slave; hready follows hreadyout
// Notes:   Expected words masked to the configured factor
`timescale 1ns/10ps
`include "lts_consts.vh"
module tb_top;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, tx_out, emul_p, emul_n, emul_oe, load_strobe, rx_valid;
    logic [9:0]  rx_word;
    logic [3:0]  fac = 4'ha;
    logic [1:0]  acc;
    logic        seen;
    logic        fwd_clk;
    logic        prev_clk;
    int          n;
    int          fail_count = 0;
    int          tests_run = 0;
    int          i, f;
    always #10 hclk = ~hclk;
    lts_serializer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_out(tx_out),
        .tx_out_emul_p(emul_p), .tx_out_emul_n(emul_n), .tx_out_emul_oe(emul_oe),
        .tx_clk_out(fwd_clk), .load_strobe(load_strobe));
    lts_rx_model u_rx (.hclk(hclk), .hresetn(hresetn), .tx_out(tx_out),
        .load_strobe(load_strobe), .fac(fac), .rx_word(rx_word), .rx_valid(rx_valid));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wait_rdy;
        logic rdy;
        rdy = 1'b0;
        while (!rdy)
        begin
            @(negedge hclk);
            rdy = hreadyout;
            rd = hrdata;
            @(posedge hclk);
        end
    endtask
    // Called just after a rising edge; returns at the edge ending the data phase
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic get_rx(input logic [9:0] exp);
        logic [9:0] m;
        m = (10'h1 << fac) - 10'h1;
        seen = 1'b0;
        for (i = 0; i < 40 && !seen; i++)
        begin
            @(negedge hclk);
            seen = rx_valid;
        end
        chk("rx_valid", 32'h1, {31'h0, seen});
        chk("rx_word", {22'h0, exp & m}, {22'h0, rx_word & m});
        @(posedge hclk);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge hclk);
        fail_count++;
        end_of_test();
    end
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, `LTS_OFF_CTRL, 32'h0);
        chk("ctrl_reset", 32'h0000_0a00, rd);
        bus(1'b1, 12'h020, 32'hffff_ffff);
        bus(1'b0, 12'h020, 32'h0);
        chk("unmapped", 32'h0, rd);
        // Every factor, two words back to back, junk above bit 9
        for (f = 3; f <= 10; f++)
        begin
            fac <= f[3:0];
            bus(1'b1, `LTS_OFF_CTRL, {20'h0, f[3:0], 8'h01});
            bus(1'b1, `LTS_OFF_DATA, 32'h0000_02b5);
            bus(1'b1, `LTS_OFF_DATA, 32'hffff_f14a);
            get_rx(10'h2b5);
            get_rx(10'h14a);
        end
        bus(1'b1, `LTS_OFF_CTRL, 32'h0000_0a00);
        for (i = 0; i < 16; i++)
            bus(1'b1, `LTS_OFF_DATA, i);
        bus(1'b0, `LTS_OFF_STATUS, 32'h0);
        chk("fifo_level", 32'h10, rd & 32'h1f);
        bus(1'b1, `LTS_OFF_CTRL, 32'h0000_0a01);
        repeat (200) @(posedge hclk);
        bus(1'b0, `LTS_OFF_STATUS, 32'h0);
        chk("status", 32'h0020_0040, rd & 32'hffff_005f);
        bus(1'b1, `LTS_OFF_CTRL, 32'h0000_0a19);
        bus(1'b1, `LTS_OFF_DATA, 32'h3ff);
        acc = 2'b00;
        repeat (30)
        begin
            @(negedge hclk);
            acc = acc | {tx_out, emul_p};
        end
        chk("line_use", 32'h1, {30'h0, acc});
        chk("emul_oe_on", 32'h1, {31'h0, emul_oe});
        @(posedge hclk);
        bus(1'b1, `LTS_OFF_CTRL, 32'h0000_0a09);
        repeat (2) @(negedge hclk);
        chk("emul_oe_off", 32'h0, {31'h0, emul_oe});
        @(posedge hclk);
        // Bypass widths: SDR sends bit 0, DDR bits 1:0 high first
        fac <= 4'h1;
        bus(1'b1, `LTS_OFF_CTRL, 32'h0000_0a03);
        bus(1'b1, `LTS_OFF_DATA, 32'h0000_0001);
        get_rx(10'h001);
        fac <= 4'h2;
        bus(1'b1, `LTS_OFF_CTRL, 32'h0000_0a05);
        bus(1'b1, `LTS_OFF_DATA, 32'h0000_0002);
        get_rx(10'h002);
        // Forwarded clock at factor 4 toggles every second bit
        bus(1'b1, `LTS_OFF_CTRL, 32'h0000_0420);
        repeat (4) @(negedge hclk);
        n = 0;
        prev_clk = fwd_clk;
        repeat (16)
        begin
            @(negedge hclk);
            if (fwd_clk !== prev_clk)
                n++;
            prev_clk = fwd_clk;
        end
        chk("fwd_clk_toggles", 32'h8, n);
        end_of_test();
    end
endmodule
